// ===== src/lpw_pkg.sv
package lpw_pkg;
  // register byte offsets on the avalon slave
  localparam logic [4:0] ADDR_CTRL1 = 5'h00;
  localparam logic [4:0] ADDR_CTRL2 = 5'h04;
  localparam logic [4:0] ADDR_CMP1 = 5'h08;
  localparam logic [4:0] ADDR_CMP0 = 5'h0c;
  localparam logic [4:0] ADDR_COUNT = 5'h10;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h14;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h18;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h1c;

  // timer_control_one fields
  localparam int CR1_PS_LSB = 0;
  localparam int CR1_PS_MSB = 2;
  localparam int CR1_SRC_LO = 3;
  localparam int CR1_SRC_HI = 4;
  localparam int CR1_M1E = 5;
  localparam int CR1_START = 6;
  localparam logic [7:0] CR1_MASK = 8'h7f;

  // timer_control_two fields
  localparam int CR2_PWM_ENABLE = 0;
  localparam int CR2_OUTPUT_POLARITY = 1;
  localparam int CR2_OUTPUT_LEVEL = 2;
  localparam logic [7:0] CR2_MASK = 8'h07;

  // interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IRQ_M1 = 0;
  localparam int IRQ_M0 = 1;

  // reset values
  localparam logic [7:0] CR1_RST = 8'h00;
  localparam logic [7:0] CR2_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'hffff;

  // source select codes {high, low}
  localparam logic [1:0] SRC_SUB = 2'h0;
  localparam logic [1:0] SRC_WDT = 2'h2;
  localparam logic [1:0] SLOW_INTERNAL_OSCILLATOR_LAST = 2'h3;

  // prescale codes
  localparam logic [2:0] PS_DIV1 = 3'h0;
  localparam logic [2:0] PS_DIV2 = 3'h1;
  localparam logic [2:0] PS_DIV4 = 3'h2;
  localparam logic [2:0] PS_DIV8 = 3'h3;
  localparam logic [2:0] PS_DIV16 = 3'h4;
  localparam logic [2:0] PS_DIV32 = 3'h5;
  localparam int PRE_W = 5;

  // source index inside the synchroniser vectors
  localparam int SRC_N = 3;
  localparam int IDX_SUB = 0;
  localparam int IDX_SLOW_INTERNAL_OSCILLATOR = 1;
  localparam int IDX_WDT = 2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } lpw_bus_t;
endpackage

// ===== src/lpw_tick_gen.sv
`timescale 1ns/100ps
module lpw_tick_gen
  import lpw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sub_clk,
  input wire logic slow_internal_oscillator_clk,
  input wire logic wdt_clk,
  input wire logic [1:0] src_sel,
  input wire logic [2:0] prescale_select,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [SRC_N-1:0] s1;
    logic [SRC_N-1:0] s2;
    logic [SRC_N-1:0] s3;
    logic [1:0] slow_internal_oscillator_cnt;
    logic [PRE_W-1:0] pre_cnt;
    logic tick;
  } lpw_tick_st_t;

  lpw_tick_st_t q_r;
  lpw_tick_st_t q_nxt;

  function automatic logic [PRE_W-1:0] div_last(input logic [2:0] ps);
    case (ps)
      PS_DIV1: div_last = 5'h00;
      PS_DIV2: div_last = 5'h01;
      PS_DIV4: div_last = 5'h03;
      PS_DIV8: div_last = 5'h07;
      PS_DIV16: div_last = 5'h0f;
      PS_DIV32: div_last = 5'h1f;
      default: div_last = 5'h00;  // prohibited codes fall back to no division
    endcase
  endfunction

  logic [SRC_N-1:0] rise;
  logic slow_internal_oscillator_tick;
  logic src_tick;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = {wdt_clk, slow_internal_oscillator_clk, sub_clk};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    rise = q_r.s2 & ~q_r.s3;
    slow_internal_oscillator_tick = rise[IDX_SLOW_INTERNAL_OSCILLATOR] && (q_r.slow_internal_oscillator_cnt == SLOW_INTERNAL_OSCILLATOR_LAST);
    if (rise[IDX_SLOW_INTERNAL_OSCILLATOR]) begin
      q_nxt.slow_internal_oscillator_cnt = q_r.slow_internal_oscillator_cnt + 2'h1;
    end
    case (src_sel)
      SRC_SUB: src_tick = rise[IDX_SUB];
      SRC_WDT: src_tick = rise[IDX_WDT];
      default: src_tick = slow_internal_oscillator_tick;
    endcase
    q_nxt.tick = 1'b0;
    // edges are only seen reliably while ref_clk is at least four times the source
    if (!run) begin
      q_nxt.pre_cnt = '0;
    end else if (src_tick) begin
      if (q_r.pre_cnt >= div_last(prescale_select)) begin
        q_nxt.pre_cnt = '0;
        q_nxt.tick = 1'b1;
      end else begin
        q_nxt.pre_cnt = q_r.pre_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign tick = q_r.tick;
endmodule

// ===== src/lpw_timer.sv
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
module lpw_timer
  import lpw_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sub_clk,
  input wire logic slow_internal_oscillator_clk,
  input wire logic wdt_clk,
  input wire logic standby,
  output logic match_zero_event,
  output logic match_one_event,
  output logic timer_output_pin,
  output logic irq
);
  typedef struct packed {
    lpw_bus_t bus;
    logic [31:0] rdata;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [CNT_W-1:0] cmp1;
    logic [CNT_W-1:0] cmp0;
    logic [CNT_W-1:0] cnt;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] irq_en;
    logic out_lvl;
    logic ev0;
    logic ev1;
  } lpw_state_t;

  lpw_state_t q_r;
  lpw_state_t q_nxt;

  logic tick;
  logic run;

  assign run = q_r.cr1[CR1_START];

  lpw_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sub_clk(sub_clk),
    .slow_internal_oscillator_clk(slow_internal_oscillator_clk),
    .wdt_clk(wdt_clk),
    .src_sel({q_r.cr1[CR1_SRC_HI], q_r.cr1[CR1_SRC_LO]}),
    .prescale_select(q_r.cr1[CR1_PS_MSB:CR1_PS_LSB]),
    .run(run),
    .tick(tick)
  );

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  function automatic logic [31:0] zext(input logic [CNT_W-1:0] v);
    zext = 32'(v);
  endfunction

  logic bus_req;
  logic bus_wr;
  logic hit0;
  logic hit1;
  logic m0;
  logic m1;
  logic pwm_on;
  logic [IRQ_W-1:0] set_v;
  logic [IRQ_W-1:0] clr_v;
  logic [31:0] rd_v;
  logic [31:0] wm_v;

  always_comb begin
    q_nxt = q_r;
    bus_req = avs_read || avs_write;
    bus_wr = avs_write && (q_r.bus == BUS_ACK);
    clr_v = '0;
    rd_v = 32'h0000_0000;
    wm_v = 32'h0000_0000;

    // bus handshake: one wait cycle for every access
    case (q_r.bus)
      BUS_IDLE: begin
        if (bus_req) begin
          q_nxt.bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        q_nxt.bus = BUS_IDLE;
      end
      default: begin
        q_nxt.bus = BUS_IDLE;
      end
    endcase

    // read mux, registered so data stands at the accepting edge
    case (avs_address)
      ADDR_CTRL1: rd_v = {24'h000000, q_r.cr1};
      ADDR_CTRL2: rd_v = {24'h000000, q_r.cr2};
      ADDR_CMP1: rd_v = zext(q_r.cmp1);
      ADDR_CMP0: rd_v = zext(q_r.cmp0);
      ADDR_COUNT: rd_v = zext(q_r.cnt);
      ADDR_IRQ_STATUS: rd_v = 32'(q_r.status);
      ADDR_IRQ_ENABLE: rd_v = 32'(q_r.irq_en);
      default: rd_v = 32'h0000_0000;
    endcase
    if (avs_read && (q_r.bus == BUS_IDLE)) begin
      q_nxt.rdata = rd_v;
    end

    if (bus_wr) begin
      case (avs_address)
        ADDR_CTRL1: begin
          wm_v = be_merge({24'h000000, q_r.cr1}, avs_writedata, avs_byteenable);
          q_nxt.cr1 = wm_v[7:0] & CR1_MASK;
        end
        ADDR_CTRL2: begin
          wm_v = be_merge({24'h000000, q_r.cr2}, avs_writedata, avs_byteenable);
          q_nxt.cr2 = wm_v[7:0] & CR2_MASK;
        end
        ADDR_CMP1: begin
          wm_v = be_merge(zext(q_r.cmp1), avs_writedata, avs_byteenable);
          q_nxt.cmp1 = wm_v[CNT_W-1:0];
        end
        ADDR_CMP0: begin
          wm_v = be_merge(zext(q_r.cmp0), avs_writedata, avs_byteenable);
          q_nxt.cmp0 = wm_v[CNT_W-1:0];
        end
        ADDR_IRQ_CLEAR: clr_v = avs_byteenable[0] ? avs_writedata[IRQ_W-1:0] : '0;
        ADDR_IRQ_ENABLE: begin
          if (avs_byteenable[0]) begin
            q_nxt.irq_en = avs_writedata[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // counter: standby has no say in counting, only in the match zero event and its status bit
    hit0 = (q_r.cnt == q_r.cmp0);
    hit1 = (q_r.cnt == q_r.cmp1);
    m0 = tick && hit0;
    m1 = tick && hit1 && q_r.cr1[CR1_M1E];
    q_nxt.ev0 = m0 && standby;
    q_nxt.ev1 = m1;
    if (!run) begin
      q_nxt.cnt = '0;
    end else if (m0) begin
      q_nxt.cnt = '0;
    end else if (tick) begin
      q_nxt.cnt = q_r.cnt + CNT_W'(1);
    end

    // pwm waveform before polarity; idle level while pwm is off or stopped
    pwm_on = q_r.cr2[CR2_PWM_ENABLE] && run;
    if (!pwm_on || m0) begin
      q_nxt.out_lvl = q_r.cr2[CR2_OUTPUT_LEVEL];
    end else if (m1) begin
      q_nxt.out_lvl = ~q_r.cr2[CR2_OUTPUT_LEVEL];
    end

    // sticky status, an event in the clearing cycle wins
    set_v = '0;
    set_v[IRQ_M1] = m1;
    set_v[IRQ_M0] = m0 && standby;
    q_nxt.status = (q_r.status & ~clr_v) | set_v;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r.bus <= BUS_IDLE;
      q_r.rdata <= 32'h0000_0000;
      q_r.cr1 <= CR1_RST;
      q_r.cr2 <= CR2_RST;
      q_r.cmp1 <= CNT_W'(CMP_RST);
      q_r.cmp0 <= CNT_W'(CMP_RST);
      q_r.cnt <= '0;
      q_r.status <= '0;
      q_r.irq_en <= '0;
      q_r.out_lvl <= 1'b0;
      q_r.ev0 <= 1'b0;
      q_r.ev1 <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (q_r.bus != BUS_ACK);
  assign avs_readdata = q_r.rdata;
  assign match_zero_event = q_r.ev0;
  assign match_one_event = q_r.ev1;
  assign timer_output_pin = q_r.out_lvl ^ q_r.cr2[CR2_OUTPUT_POLARITY];
  assign irq = |(q_r.status & q_r.irq_en);
endmodule

// ===== verification/lpw_timer_checker.sv
`timescale 1ns/100ps
module lpw_timer_checker #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic standby,
  input wire logic match_zero_event,
  input wire logic match_one_event,
  input wire logic timer_output_pin,
  input wire logic irq
);
  logic ev;
  logic acc;
  assign ev = match_zero_event | match_one_event;
  assign acc = avs_write & ~avs_waitrequest;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // sources run at most a quarter of ref_clk, so ticks never crowd
  chk_m0_spacing: assert property (match_zero_event |=> !match_zero_event [*3])
    else $error("m0 too close");
  chk_m1_spacing: assert property (match_one_event |=> !match_one_event [*3])
    else $error("m1 too close");
  chk_m0_standby: assert property (match_zero_event |-> $past(standby))
    else $error("m0 awake");
  chk_irq_rise: assert property ($rose(irq) |-> ev || $past(ev) || $past(acc))
    else $error("irq rose alone");
  chk_irq_fall: assert property ($fell(irq) |-> $past(acc))
    else $error("irq fell alone");
  chk_wait_one: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("two wait cycles");
  chk_req_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  // awake, a suppressed clear may restore the pin with no event
  chk_pin_still:
  assert property (standby && $changed(timer_output_pin) |-> ev || $past(ev) || $past(acc) || $past(acc, 2))
    else $error("pin moved alone");
endmodule

// ===== verification/tb_lpw_timer.sv
`timescale 1ns/100ps
module tb_lpw_timer;
  import lpw_pkg::*;
  logic ref_clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, standby = 1'h0;
  logic sub_clk = 1'h0, slow_internal_oscillator_clk = 1'h0, wdt_clk = 1'h0;
  logic [4:0] avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, match_zero_event, match_one_event, timer_output_pin, irq;
  int num_errors, cmp_count, tc;
  lpw_timer i_lpw_timer (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .sub_clk, .slow_internal_oscillator_clk, .wdt_clk, .standby, .match_zero_event,
    .match_one_event, .timer_output_pin, .irq);
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin  // sources stay well below a quarter of ref_clk
    tc <= tc + 1;
    sub_clk <= tc[3];
    slow_internal_oscillator_clk <= tc[2];  // keeps running through standby
    wdt_clk <= tc % 24 >= 12;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'h0 && ++n < 50);
    rd = avs_readdata;
    chk(avs_waitrequest, 1'h0, "waitrequest");
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task ev_at(input logic z, output int t);
    int n;
    n = 0;
    do @(negedge ref_clk); while ((z ? match_zero_event : match_one_event) !== 1'h1 && ++n < 5000);
    if (n >= 5000) begin
      num_errors++;
    end
    t = tc;
  endtask
  task gap(input logic z, input int e);
    int a, b;
    ev_at(z, a);
    ev_at(z, a);  // first event may still come from the old setting
    ev_at(z, b);
    chk(b - a, e, "spacing");
  endtask
  task t_regs;
    for (int i = 0; i < 8; i++) begin
      bus(1'h0, 5'(i * 4), 32'h0);
      chk(rd, i == 2 || i == 3 ? 32'hffff : 32'h0, "reset");
    end
    bus(1'h1, ADDR_COUNT, 32'h5);
    bus(1'h0, ADDR_COUNT, 32'h0);
    chk(rd, 32'h0, "count");
    bus(1'h1, ADDR_CTRL2, 32'hff);
    bus(1'h0, ADDR_CTRL2, 32'h0);
    chk(rd, 32'h7, "ctrl2 mask");
    bus(1'h1, ADDR_CTRL2, 32'h0);
    bus(1'h1, ADDR_CMP1, 32'h1234);
    avs_byteenable <= 4'h1;
    bus(1'h1, ADDR_CMP1, 32'hffab);
    avs_byteenable <= 4'hf;
    bus(1'h0, ADDR_CMP1, 32'h0);
    chk(rd, 32'h12ab, "cmp1 lanes");
    bus(1'h0, 5'h2, 32'h0);
    chk(rd, 32'h0, "unmapped");
    $display("regs done");
  endtask
  task t_rate;
    int p [4] = '{16, 32, 24, 32};
    bus(1'h1, ADDR_CMP0, 32'h3);
    bus(1'h1, ADDR_CMP1, 32'h1);
    for (int i = 0; i < 9; i++) begin
      int s, d;
      s = i > 5 ? i - 5 : 0;
      d = i > 5 ? 0 : i;
      bus(1'h1, ADDR_CTRL1, 32'(8'h60 | s << 3 | d));  // prescale stays 0 to 5
      gap(1'h0, 4 * p[s] << d);
    end
    chk(irq, 1'h0, "masked");
    $display("rate done");
  endtask
  task t_stby;
    int n;
    bus(1'h1, ADDR_CTRL1, 32'h40);
    bus(1'h1, ADDR_IRQ_CLEAR, 32'h3);
    bus(1'h1, ADDR_IRQ_ENABLE, 32'h3);
    standby <= 1'h1;
    gap(1'h1, 64);
    bus(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h2, "status");
    chk(irq, 1'h1, "irq");
    standby <= 1'h0;
    bus(1'h1, ADDR_IRQ_CLEAR, 32'h2);
    @(negedge ref_clk);
    chk(irq, 1'h0, "cleared");
    n = 0;
    repeat (200) @(negedge ref_clk) n += match_zero_event;
    chk(n, 0, "awake m0");
    bus(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0, "awake status");
    $display("standby done");
  endtask
  task t_pwm;
    int t;
    bus(1'h1, ADDR_CTRL1, 32'h60);
    standby <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      bus(1'h1, ADDR_CTRL2, 32'(i << 1 & 6 | i >> 2));
      if (i < 4) begin
        repeat (2) @(negedge ref_clk);
        chk(timer_output_pin, i[0] ^ i[1], "idle pin");
      end else begin
        repeat (2) ev_at(1'h0, t);
        repeat (2) @(negedge ref_clk);
        chk(timer_output_pin, !i[1] ^ i[0], "pin m1");
        chk(irq, 1'h1, "m1 irq");
        ev_at(1'h1, t);
        repeat (2) @(negedge ref_clk);
        chk(timer_output_pin, i[1] ^ i[0], "pin m0");
      end
    end
    $display("pwm done");
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_regs;
    t_rate;
    t_stby;
    t_pwm;
    final_report;
  end
endmodule
bind lpw_timer lpw_timer_checker #(.CNT_W(CNT_W)) i_lpw_timer_checker (.ref_clk, .rst_n, .avs_read, .avs_write,
  .avs_waitrequest, .standby, .match_zero_event, .match_one_event, .timer_output_pin, .irq);
